// File: hdl/rie_alu.sv
// Purpose: 16-bit arithmetic, logic, shift and compare unit
// Assumes: purely combinational, operands from the same clock
// Notes:   shifts use the low four bits of operand b
`timescale 1ns/1ps
module rie_alu (
   input  wire logic [3:0]  op,    // operation, rie_alu_t encoding
   input  wire logic [15:0] a,     // first operand
   input  wire logic [15:0] b,     // second operand
   output logic      [15:0] y      // result
);
   logic [3:0] amt;
   assign amt = b[3:0];

   always_comb begin
      case (rie_pkg::rie_alu_t'(op))
         rie_pkg::ALU_ADD:   y = a + b;
         rie_pkg::ALU_SUB:   y = a - b;
         rie_pkg::ALU_SLT:   y = {15'h0000, ($signed(a) < $signed(b))};
         rie_pkg::ALU_SLTU:  y = {15'h0000, (a < b)};
         rie_pkg::ALU_AND:   y = a & b;
         rie_pkg::ALU_OR:    y = a | b;
         rie_pkg::ALU_NOR:   y = ~(a | b);
         rie_pkg::ALU_XOR:   y = a ^ b;
         rie_pkg::ALU_SLL:   y = a << amt;
         rie_pkg::ALU_SRL:   y = a >> amt;
         rie_pkg::ALU_SRA:   y = $unsigned($signed(a) >>> amt);
         rie_pkg::ALU_PASSB: y = b;
         default:            y = 16'h0000;
      endcase
   end
endmodule

// File: hdl/rie_core.sv
// Purpose: decode and execute of the 16-bit load-store instruction set
// Assumes: instruction memory answers combinationally at fetch_pointer;
//          data memory read data is combinational for the current address
// Notes:   one instruction per clock while not halted; resume by restart_in
`timescale 1ns/1ps
module rie_core #(
   parameter int unsigned NREG = 8                 // working registers
) (
   input  wire logic        clk,                   // core clock, 40 MHz
   input  wire logic        rst_n,                 // async reset, low
   input  wire logic [15:0] instr_in,              // instruction word at fetch_pointer
   input  wire logic [15:0] dmem_rdata,            // data memory read word
   input  wire logic        restart_in,            // external restart from debug
   output logic      [15:0] fetch_pointer,         // instruction address
   output logic      [15:0] dmem_addr,             // data memory byte address
   output logic      [15:0] dmem_wdata,            // data memory write word
   output logic      [1:0]  dmem_we,               // byte write enables, [1] high byte
   output logic             dmem_re,               // data memory read strobe
   output logic             debug_mode,            // halted in debug
   output logic             retire_out             // one instruction executed
);
   // ======================================================================
   // state
   typedef enum logic {RIE_RUN, RIE_HALT} rie_state_t;
   rie_state_t  state_reg, state_next;
   logic [15:0] working_register [NREG];
   logic [15:0] fetch_reg, fetch_next;
   logic [10:0] pfx_reg;
   logic        pfx_valid_reg;
   logic        restart_s1_reg, restart_s2_reg;
   logic [15:0] daddr_reg, dwdata_reg;
   logic [1:0]  dwe_reg;
   logic        dre_reg, retire_reg, debug_reg;

   // ======================================================================
   // field decode
   // 16-bit word, 3-bit indices
   logic [4:0]  major;
   logic [2:0]  source_a_index, dest_index, source_b_index;
   logic [1:0]  subop;
   logic [4:0]  imm5;
   logic [7:0]  imm8;
   logic [10:0] imm11;
   assign major          = instr_in[rie_pkg::OP_HI:rie_pkg::OP_LO];
   assign source_a_index = instr_in[rie_pkg::SA_HI:rie_pkg::SA_LO];
   assign dest_index     = instr_in[rie_pkg::RD_HI:rie_pkg::RD_LO];
   assign source_b_index = instr_in[rie_pkg::SRCB_HI:rie_pkg::SRCB_LO];
   assign subop          = instr_in[rie_pkg::FN_HI:rie_pkg::FN_LO];
   assign imm5           = instr_in[rie_pkg::I5_HI:0];
   assign imm8           = instr_in[rie_pkg::I8_HI:0];
   assign imm11          = instr_in[rie_pkg::I11_HI:0];

   logic [15:0] src_a, src_b;
   assign src_a = working_register[source_a_index];
   assign src_b = working_register[source_b_index];

   logic [15:0] imm5_ext, imm8_ext;
   assign imm5_ext = pfx_valid_reg ? {pfx_reg, imm5} : {{11{imm5[4]}}, imm5};
   assign imm8_ext = pfx_valid_reg ? {pfx_reg, imm8[4:0]} : {{8{imm8[7]}}, imm8};

   // ======================================================================
   // instruction classes
   wire running     = (state_reg == RIE_RUN);
   wire is_shift_r  = (major == rie_pkg::OP_SHIFT) && (subop != rie_pkg::FN_0);
   wire is_log_r    = (major == rie_pkg::OP_LOG);
   wire is_arith_r  = (major == rie_pkg::OP_ARITH);
   wire is_shift_c  = (major == rie_pkg::OP_SLLC) || (major == rie_pkg::OP_SRLC)
                      || (major == rie_pkg::OP_SRAC);
   wire is_imm_alu  = (major >= rie_pkg::OP_ANDC) && (major <= rie_pkg::OP_SLTUC);
   wire is_ldc      = (major == rie_pkg::OP_LDC) && (source_a_index == 3'h0);
   wire is_load     = (major == rie_pkg::OP_LOAD) && (subop != rie_pkg::FN_3);
   wire is_store    = (major == rie_pkg::OP_STORE)
                      && ((subop == rie_pkg::FN_0) || (subop == rie_pkg::FN_1));
   wire is_rgoto    = (major == rie_pkg::OP_SPEC) && (subop == rie_pkg::FN_0);
   wire is_branch   = (major >= rie_pkg::OP_BZERO) && (major <= rie_pkg::OP_BLTZ);
   wire is_goto     = (major == rie_pkg::OP_GOTO);
   wire is_call     = (major == rie_pkg::OP_CALL);
   wire is_halt     = (major == rie_pkg::OP_HALT);
   wire is_pfx      = (major == rie_pkg::OP_PFX);

   // ======================================================================
   // alu operation select
   logic [3:0]  alu_op;
   logic [15:0] alu_b, alu_y;
   assign alu_op =
      is_arith_r ? 4'(rie_pkg::ALU_ADD + subop) :
      is_log_r   ? 4'(rie_pkg::ALU_AND + subop) :
      is_shift_r ? 4'(rie_pkg::ALU_SLL + subop - 2'h1) :
      is_shift_c ? 4'(rie_pkg::ALU_SLL + (major - rie_pkg::OP_SLLC)) :
      (major == rie_pkg::OP_ADDC)  ? 4'(rie_pkg::ALU_ADD)  :
      (major == rie_pkg::OP_ANDC)  ? 4'(rie_pkg::ALU_AND)  :
      (major == rie_pkg::OP_ORC)   ? 4'(rie_pkg::ALU_OR)   :
      (major == rie_pkg::OP_NORC)  ? 4'(rie_pkg::ALU_NOR)  :
      (major == rie_pkg::OP_XORC)  ? 4'(rie_pkg::ALU_XOR)  :
      (major == rie_pkg::OP_SLTC)  ? 4'(rie_pkg::ALU_SLT)  :
      (major == rie_pkg::OP_SLTUC) ? 4'(rie_pkg::ALU_SLTU) :
      4'(rie_pkg::ALU_PASSB);
   assign alu_b = (is_arith_r || is_log_r || is_shift_r) ? src_b : imm5_ext;

   rie_alu u_alu (
      .op (alu_op),
      .a  (src_a),
      .b  (alu_b),
      .y  (alu_y)
   );

   // ======================================================================
   // load data shaping
   // byte signed, unsigned, word
   logic [7:0]  load_byte;
   logic [15:0] load_val;
   assign load_byte = src_a[0] ? dmem_rdata[15:8] : dmem_rdata[7:0];
   assign load_val  = (subop == rie_pkg::FN_0) ? {{8{load_byte[7]}}, load_byte} :
                      (subop == rie_pkg::FN_1) ? {8'h00, load_byte} : dmem_rdata;

   // ======================================================================
   // register write back
   // mult/div left out
   logic        wb_en;
   logic [2:0]  wb_idx;
   logic [15:0] wb_val;
   logic [15:0] link_val;
   assign link_val = fetch_reg + rie_pkg::FETCH_STEP;
   assign wb_en  = running && (is_shift_r || is_log_r || is_arith_r || is_shift_c
                   || is_imm_alu || is_ldc || is_load || is_call);
   assign wb_idx = is_call ? 3'(rie_pkg::LINK_REG) : dest_index;
   assign wb_val = is_call ? link_val :
                   is_load ? load_val :
                   is_ldc  ? imm5_ext : alu_y;

   // ======================================================================
   // next fetch pointer
   logic        br_taken;
   logic [15:0] br_target, jmp_target;
   assign br_taken = (major == rie_pkg::OP_BZERO) ? (src_a == 16'h0000) :
                     (major == rie_pkg::OP_BNZ)  ? (src_a != 16'h0000) :
                     (major == rie_pkg::OP_BGEZ) ? !src_a[15] : src_a[15];
   assign br_target  = fetch_reg + {imm8_ext[14:0], 1'b0};
   assign jmp_target = {fetch_reg[15:12], imm11, 1'b0};

   always_comb begin
      fetch_next = fetch_reg;
      if (running && !is_halt) begin
         if (is_branch && br_taken) begin
            fetch_next = br_target;
         end else if (is_goto || is_call) begin
            fetch_next = jmp_target;
         end else if (is_rgoto) begin
            fetch_next = {src_a[15:1], 1'b0};
         end else begin
            fetch_next = link_val;
         end
      end
   end

   // ======================================================================
   // halt state
   // halt until restart
   always_comb begin
      case (state_reg)
         RIE_RUN:  state_next = is_halt ? RIE_HALT : RIE_RUN;
         RIE_HALT: state_next = restart_s2_reg ? RIE_RUN : RIE_HALT;
         default:  state_next = RIE_RUN;
      endcase
   end

   // ======================================================================
   // memory request, registered
   // aligned address for word accesses, byte accesses keep src_a
   wire [15:0] mem_addr_c = (is_store && subop == rie_pkg::FN_1)
                            || (is_load && subop == rie_pkg::FN_2)
                            ? {src_a[15:1], 1'b0} : src_a;
   wire [1:0]  we_c = !(running && is_store) ? 2'b00 :
                      (subop == rie_pkg::FN_1) ? 2'b11 :
                      (src_a[0] ? 2'b10 : 2'b01);
   wire [15:0] wd_c = (subop == rie_pkg::FN_1) ? src_b : {src_b[7:0], src_b[7:0]};

   // ======================================================================
   // sequential state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= RIE_RUN;
         fetch_reg      <= rie_pkg::RESET_FETCH;
         restart_s1_reg <= 1'b0;
         restart_s2_reg <= 1'b0;
         debug_reg      <= 1'b0;
      end else begin
         state_reg      <= state_next;
         fetch_reg      <= fetch_next;
         restart_s1_reg <= restart_in;
         restart_s2_reg <= restart_s1_reg;
         debug_reg      <= (state_next == RIE_HALT);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pfx_reg       <= 11'h000;
         pfx_valid_reg <= 1'b0;
      end else if (running) begin
         pfx_reg       <= imm11;
         pfx_valid_reg <= is_pfx;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         daddr_reg  <= 16'h0000;
         dwdata_reg <= 16'h0000;
         dwe_reg    <= 2'b00;
         dre_reg    <= 1'b0;
         retire_reg <= 1'b0;
      end else begin
         daddr_reg  <= mem_addr_c;
         dwdata_reg <= wd_c;
         dwe_reg    <= we_c;
         dre_reg    <= running && is_load;
         retire_reg <= running;
      end
   end

   // one generate loop over the register file
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               working_register[gi] <= 16'h0000;
            end else if (wb_en && wb_idx == 3'(gi)) begin
               working_register[gi] <= wb_val;
            end
         end
      end
   endgenerate

   assign fetch_pointer = fetch_reg;
   assign dmem_addr     = daddr_reg;
   assign dmem_wdata    = dwdata_reg;
   assign dmem_we       = dwe_reg;
   assign dmem_re       = dre_reg;
   assign debug_mode    = debug_reg;
   assign retire_out    = retire_reg;

   // ======================================================================
   // checks
   AST_CALL_LINK: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_call |=> working_register[rie_pkg::LINK_REG] == $past(fetch_reg) + 16'h0002)
      else $error("call did not link pointer plus two");
   AST_GOTO_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_goto |=> fetch_reg[15:12] == $past(fetch_reg[15:12]) && !fetch_reg[0])
      else $error("goto left its page");
   AST_RGOTO_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_rgoto |=> fetch_reg == {$past(src_a[15:1]), 1'b0})
      else $error("register goto target wrong");
   AST_HALT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_halt |=> debug_mode && fetch_reg == $past(fetch_reg))
      else $error("halt did not stop execution");
   AST_HALT_NOWB: assert property (@(posedge clk) disable iff (!rst_n)
      !running |=> $stable(fetch_reg) && dmem_we == 2'b00 && !dmem_re && !retire_out)
      else $error("state changed while halted");
   AST_ZERO_FALL: assert property (@(posedge clk) disable iff (!rst_n)
      running && major == rie_pkg::OP_BZERO && src_a != 16'h0000 |=>
      fetch_reg == $past(fetch_reg) + 16'h0002)
      else $error("zero branch taken wrongly");
   AST_SLT_BOOL: assert property (@(posedge clk) disable iff (!rst_n)
      wb_en && (is_arith_r && subop[1]) |-> wb_val inside {16'h0000, 16'h0001})
      else $error("compare result not one or zero");
   AST_WORD_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_load && subop == rie_pkg::FN_2 |=> dmem_re && !dmem_addr[0])
      else $error("word load address not aligned");
   AST_WSTORE_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_store && subop == rie_pkg::FN_1 |=> dmem_we == 2'b11 && !dmem_addr[0])
      else $error("word store enables wrong");
   AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
      major >= 5'h1A || major == rie_pkg::OP_MULDV |-> !wb_en)
      else $error("reserved code wrote a register");
   AST_PFX_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
      running && !is_pfx |=> !pfx_valid_reg)
      else $error("prefix lived past next instruction");
   AST_RESV_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      running && major == rie_pkg::OP_TRAP |=> fetch_reg == $past(fetch_reg) + 16'h0002)
      else $error("reserved code did not act as idle");
   AST_LOAD_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
      running && is_load |=> dmem_re && dmem_we == 2'b00)
      else $error("load did not raise read strobe");
   AST_RETIRE: assert property (@(posedge clk) disable iff (!rst_n)
      running |=> retire_out)
      else $error("executed instruction not retired");
   AST_ADD_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
      wb_en && is_arith_r && subop == rie_pkg::FN_0 |-> wb_val == 16'(src_a + src_b))
      else $error("sum did not wrap in sixteen bits");
   AST_SRA_FILL: assert property (@(posedge clk) disable iff (!rst_n)
      wb_en && major == rie_pkg::OP_SRAC && src_a[15] |-> wb_val[15])
      else $error("arithmetic shift lost the sign");
   AST_BR_TAKEN: assert property (@(posedge clk) disable iff (!rst_n)
      running && major == rie_pkg::OP_BNZ && src_a != 16'h0000 && !pfx_valid_reg |=>
      fetch_reg == $past(fetch_reg) + {{7{$past(imm8[7])}}, $past(imm8), 1'b0})
      else $error("nonzero branch not taken");
endmodule

// File: hdl/rie_pkg.sv
// Purpose: constants for the 16-bit instruction execute block
// Assumes: one clock, byte-addressed data memory with 16-bit words
// Notes:   field positions and major codes used by the core, alu operations shared with the alu
package rie_pkg;
   // ======================================================================
   // field layout
   localparam int unsigned OP_HI   = 15;
   localparam int unsigned OP_LO   = 11;
   localparam int unsigned SA_HI   = 10;
   localparam int unsigned SA_LO   = 8;
   localparam int unsigned RD_HI   = 7;
   localparam int unsigned RD_LO   = 5;
   localparam int unsigned SRCB_HI = 4;
   localparam int unsigned SRCB_LO = 2;
   localparam int unsigned FN_HI   = 1;
   localparam int unsigned FN_LO   = 0;
   localparam int unsigned I5_HI   = 4;
   localparam int unsigned I8_HI   = 7;
   localparam int unsigned I11_HI  = 10;
   localparam int unsigned LINK_REG = 7;
   localparam logic [15:0] RESET_FETCH = 16'h0000;
   localparam logic [15:0] FETCH_STEP  = 16'h0002;
   // ======================================================================
   // major codes
   localparam logic [4:0] OP_SHIFT = 5'h00;
   localparam logic [4:0] OP_LOG   = 5'h01;
   localparam logic [4:0] OP_ARITH = 5'h02;
   localparam logic [4:0] OP_MULDV = 5'h03;
   localparam logic [4:0] OP_LOAD  = 5'h04;
   localparam logic [4:0] OP_STORE = 5'h05;
   localparam logic [4:0] OP_SPEC  = 5'h06;
   localparam logic [4:0] OP_SLLC  = 5'h07;
   localparam logic [4:0] OP_SRLC  = 5'h08;
   localparam logic [4:0] OP_SRAC  = 5'h09;
   localparam logic [4:0] OP_ANDC  = 5'h0A;
   localparam logic [4:0] OP_ORC   = 5'h0B;
   localparam logic [4:0] OP_NORC  = 5'h0C;
   localparam logic [4:0] OP_XORC  = 5'h0D;
   localparam logic [4:0] OP_ADDC  = 5'h0E;
   localparam logic [4:0] OP_SLTC  = 5'h0F;
   localparam logic [4:0] OP_SLTUC = 5'h10;
   localparam logic [4:0] OP_LDC   = 5'h11;
   localparam logic [4:0] OP_BZERO = 5'h12;
   localparam logic [4:0] OP_BNZ   = 5'h13;
   localparam logic [4:0] OP_BGEZ  = 5'h14;
   localparam logic [4:0] OP_BLTZ  = 5'h15;
   localparam logic [4:0] OP_GOTO  = 5'h16;
   localparam logic [4:0] OP_CALL  = 5'h17;
   localparam logic [4:0] OP_HALT  = 5'h18;
   localparam logic [4:0] OP_PFX   = 5'h19;
   localparam logic [4:0] OP_TRAP  = 5'h1A;
   // ======================================================================
   // sub codes
   localparam logic [1:0] FN_0 = 2'h0;
   localparam logic [1:0] FN_1 = 2'h1;
   localparam logic [1:0] FN_2 = 2'h2;
   localparam logic [1:0] FN_3 = 2'h3;
   // ======================================================================
   // alu operations
   typedef enum logic [3:0] {
      ALU_ADD, ALU_SUB, ALU_SLT, ALU_SLTU, ALU_AND, ALU_OR, ALU_NOR,
      ALU_XOR, ALU_SLL, ALU_SRL, ALU_SRA, ALU_PASSB
   } rie_alu_t;
endpackage

// File: testbench/rie_core_tb.sv
// Purpose: lockstep self-checking bench for rie_core
// Assumes: bench feeds instr_in in program order and models the core
// Notes:   register contents are made visible through word stores
`timescale 1ns/1ps
module rie_core_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] instr_in = 16'h0000;
   logic [15:0] maddr = 16'h0000;
   logic        restart_in = 1'b0;
   logic [15:0] dmem_rdata, fetch_pointer, dmem_addr, dmem_wdata;
   logic [1:0]  dmem_we;
   logic        dmem_re, debug_mode, retire_out;
   logic [15:0] rf [8];
   logic [15:0] rmem [32768];
   logic [15:0] pc_e, addr_e, wd_e, r;
   logic [1:0]  we_e;
   logic        re_e, dbg_e, pfx_v;
   logic [10:0] pfx;
   int          fail_count = 0;
   int          check_count = 0;
   always #12.5 clk = ~clk;
   rie_core i_dut (.clk(clk), .rst_n(rst_n), .instr_in(instr_in), .dmem_rdata(dmem_rdata),
      .restart_in(restart_in), .fetch_pointer(fetch_pointer), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
      .debug_mode(debug_mode), .retire_out(retire_out));
   rie_dmem_model i_mem (.clk(clk), .rd_addr(maddr), .we(dmem_we), .waddr(dmem_addr),
      .wdata(dmem_wdata), .rdata(dmem_rdata));
   // ======================================================================
   // checking and reference model
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic logic [15:0] ex(input logic [3:0] s, input logic [15:0] a, b);
      case (s)
         4'h1: return a << b[3:0];
         4'h2: return a >> b[3:0];
         4'h3: return $unsigned($signed(a) >>> b[3:0]);
         4'h4: return a & b;
         4'h5: return a | b;
         4'h6: return ~(a | b);
         4'h7: return a ^ b;
         4'h8: return a + b;
         4'h9: return a - b;
         4'hA: return {15'h0000, $signed(a) < $signed(b)};
         4'hB: return {15'h0000, a < b};
         default: return 16'h0000;
      endcase
   endfunction
   task automatic model(input logic [15:0] ins);
      logic [4:0]  op;
      logic [15:0] a, b, im, w, v, pc0, off;
      logic [7:0]  bt;
      logic        wr;
      op = ins[15:11];
      a = rf[ins[10:8]];
      b = rf[ins[4:2]];
      im = pfx_v ? {pfx, ins[4:0]} : {{11{ins[4]}}, ins[4:0]};
      off = pfx_v ? {pfx[9:0], ins[4:0], 1'b0} : {{7{ins[7]}}, ins[7:0], 1'b0};
      w = rmem[a[15:1]];
      pc0 = pc_e;
      pc_e = pc0 + 16'h0002;
      pfx_v = 1'b0;
      we_e = 2'h0;
      re_e = 1'b0;
      wr = 1'b1;
      v = 16'h0000;
      case (op)
         5'h00, 5'h01, 5'h02: begin
            v = ex({op[1:0], ins[1:0]}, a, b);
            wr = op != 5'h00 || ins[1:0] != 2'h0;
         end
         5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E: v = ex(4'(op - 5'h06), a, im);
         5'h0F, 5'h10: v = ex(4'(op - 5'h05), a, im);
         5'h11: begin
            v = im;
            wr = ins[10:8] == 3'h0;
         end
         5'h04: begin
            re_e = ins[1:0] != 2'h3;
            wr = re_e;
            addr_e = ins[1:0] == 2'h2 ? {a[15:1], 1'b0} : a;
            bt = a[0] ? w[15:8] : w[7:0];
            v = ins[1:0] == 2'h2 ? w : {{8{bt[7] & ~ins[0]}}, bt};
         end
         5'h05: begin
            wr = 1'b0;
            if (ins[1] == 1'b0) begin
               we_e = ins[0] ? 2'h3 : (a[0] ? 2'h2 : 2'h1);
               addr_e = ins[0] ? {a[15:1], 1'b0} : a;
               wd_e = ins[0] ? b : {b[7:0], b[7:0]};
               if (we_e[0]) rmem[a[15:1]][7:0] = wd_e[7:0];
               if (we_e[1]) rmem[a[15:1]][15:8] = wd_e[15:8];
            end
         end
         5'h06: begin
            wr = 1'b0;
            if (ins[1:0] == 2'h0) pc_e = {a[15:1], 1'b0};
         end
         5'h12, 5'h13, 5'h14, 5'h15: begin
            wr = 1'b0;
            if (op[2] ? (op[0] ? a[15] : !a[15]) : (op[0] ? a != 0 : a == 0))
               pc_e = pc0 + off;
         end
         5'h16, 5'h17: begin
            wr = op[0];
            v = pc0 + 16'h0002;
            pc_e = {pc0[15:12], ins[10:0], 1'b0};
         end
         5'h18: begin
            wr = 1'b0;
            dbg_e = 1'b1;
            pc_e = pc0;
         end
         5'h19: begin
            wr = 1'b0;
            pfx_v = 1'b1;
            pfx = ins[10:0];
         end
         default: wr = 1'b0;
      endcase
      if (wr) rf[op == 5'h17 ? 3'h7 : ins[7:5]] = v;
   endtask
   // drive at an executing edge, check the previous instruction, model this one
   task automatic step(input logic [15:0] ins);
      instr_in <= ins;
      maddr <= rf[ins[10:8]];
      @(negedge clk);
      chk("fetch_pointer", pc_e, fetch_pointer);
      chk("debug_mode", {15'h0000, dbg_e}, {15'h0000, debug_mode});
      chk("retire_out", 16'h0001, {15'h0000, retire_out});
      chk("dmem_we", {14'h0000, we_e}, {14'h0000, dmem_we});
      chk("dmem_re", {15'h0000, re_e}, {15'h0000, dmem_re});
      if (we_e != 2'h0 || re_e) chk("dmem_addr", addr_e, dmem_addr);
      if (we_e != 2'h0) chk("dmem_wdata", wd_e, dmem_wdata);
      model(ins);
      @(posedge clk);
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      instr_in <= 16'h0000;
      restart_in <= 1'b0;
      repeat (16) @(posedge clk);
      chk("reset_state", 16'h0000, fetch_pointer | dmem_addr | dmem_wdata |
          {11'h000, dmem_we, dmem_re, debug_mode, retire_out});
      for (int i = 0; i < 8; i++) rf[i] = 16'h0000;
      pc_e = 16'h0000;
      pfx_v = 1'b0;
      dbg_e = 1'b0;
      rst_n <= 1'b1;
      model(16'h0000);
      @(posedge clk);
   endtask
   task automatic halt_test();
      logic [15:0] hp;
      int          n;
      step({5'h18, 11'h2A5});
      hp = pc_e;
      instr_in <= 16'h0000;
      repeat (4) begin
         @(negedge clk);
         chk("halt_pointer", hp, fetch_pointer);
         chk("halt_debug", 16'h0001, {15'h0000, debug_mode});
         @(posedge clk);
      end
      restart_in <= 1'b1;
      @(posedge clk);
      restart_in <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (debug_mode !== 1'b0 && n < 8);
      chk("restart_debug", 16'h0000, {15'h0000, debug_mode});
      chk("restart_pointer", hp, fetch_pointer);
      dbg_e = 1'b0;
      model(16'h0000);
      @(posedge clk);
   endtask
   // ======================================================================
   // test sequence
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("BAD watchdog expected finish seen timeout");
      stop_test();
   end
   initial begin
      void'($urandom(66));
      for (int i = 0; i < 32768; i++) rmem[i] = 16'(i) ^ 16'hC3A5;
      do_reset();
      for (int i = 0; i < 8; i++) begin
         step({5'h19, 11'($urandom)});
         step({5'h11, 3'h0, 3'(i), 5'($urandom)});
      end
      step({5'h19, 11'($urandom)});
      step({5'h13, 3'h1, 8'($urandom)});
      $display("test seed done");
      for (int k = 0; k < 400; k++) begin
         r = 16'($urandom);
         if (r[15:11] == 5'h18) r[15:11] = 5'h1B;
         if (r[15:11] == 5'h19) begin
            step(r);
            r[15:11] = 5'h0A + 5'($urandom_range(7));
         end
         step(r);
         step({5'h05, r[7:5], 3'h0, r[7:5], 2'h1});
         step(16'h0000);
      end
      $display("test random done");
      halt_test();
      $display("test halt done");
      step({5'h19, 11'h3FF});
      do_reset();
      step({5'h11, 3'h0, 3'h1, 5'h1F});
      step({5'h05, 3'h1, 3'h0, 3'h1, 2'h1});
      step(16'h0000);
      $display("test reset done");
      stop_test();
   end
endmodule

// File: testbench/rie_dmem_model.sv
// Purpose: data memory on the far side of the core
// Assumes: reads combinational, writes land one clock after dmem_we shows
// Notes:   contents start from a fixed address-derived pattern
`timescale 1ns/1ps
module rie_dmem_model (
   input  wire logic        clk,      // core clock
   input  wire logic [15:0] rd_addr,  // byte address being read
   input  wire logic [1:0]  we,       // byte write enables
   input  wire logic [15:0] waddr,    // byte address of the write
   input  wire logic [15:0] wdata,    // write word
   output logic      [15:0] rdata     // word holding rd_addr
);
   logic [15:0] mem [32768];
   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 16'(i) ^ 16'hC3A5;
      end
   end
   assign rdata = mem[rd_addr[15:1]];
   always @(posedge clk) begin
      if (we[0]) mem[waddr[15:1]][7:0] <= wdata[7:0];
      if (we[1]) mem[waddr[15:1]][15:8] <= wdata[15:8];
   end
endmodule
